// file: isrc_top.sv
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Interrupt sources, reset cause register and context capture.
// Assumes pins are asynchronous; the core drives entry and context values.
// Summary of operation
// - Priority enable bit selects two-level mode
// - Reset cause holds brown-out enable and flags
// - Bit five always reads zero
// - Timeout, power-down read-only; printed reset values
// - Edge select picks rising or falling edge
// - Selected edge sets flag; enable gates request
// - Enabled pin edge wakes from idle or sleep
// - Wake with global enable branches to vector
// - Pins one and two use own priority
// - Pin zero is always high priority
// - Eight-bit rollover sets timer flag
// - Sixteen-bit rollover sets timer flag
// - Timer enable gates; priority from second register
// - Upper port pin change sets change flag
// - Per-pin change enable, own enable, priority
// - Entry saves return address and working context
// - Priority bit one means high
module isrc_top (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] ext_irq_pin,
   input wire logic [3:0] port_change_pin,
   input wire logic low_power_mode,
   input wire logic irq_entry,
   input wire logic [15:0] return_pc,
   input wire logic [7:0] working_register,
   input wire logic [7:0] status_register,
   input wire logic [7:0] bank_select_register,
   input wire logic cause_reset_instr,
   input wire logic cause_watchdog,
   input wire logic cause_sleep,
   output logic irq_high,
   output logic irq_low,
   output logic wake_up,
   output logic branch_vector,
   output logic priority_levels_enable
);
   typedef struct packed {
      logic [7:0] reset_cause_control;
      logic [7:0] irq_control_main;
      logic [7:0] irq_control_second;
      logic [7:0] irq_control_third;
      logic [3:0] pin_change_enable_mask;
      logic [7:0] timer_count_low;
      logic [7:0] timer_count_high;
      logic [7:0] timer_cfg;
      logic [2:0] ext_meta;
      logic [2:0] ext_sync;
      logic [2:0] ext_prev;
      logic [3:0] chg_meta;
      logic [3:0] chg_sync;
      logic [3:0] chg_prev;
      logic [2:0] wake_armed;
      logic rd_shadow;
      logic [7:0] rd_data;
      logic irq_high;
      logic irq_low;
      logic wake_up;
      logic branch_vector;
   } isrc_state_t;

   isrc_state_t st_reg;
   isrc_state_t st_next;
   logic [7:0] shadow_rdata;
   logic [2:0] shadow_addr;
   logic [2:0] ext_flag;
   logic [2:0] ext_en;
   logic [2:0] ext_prio;
   logic [2:0] ext_edge;
   logic [2:0] ext_event;
   logic [3:0] chg_event;
   logic timer_wrap;
   logic [8:0] low_sum;
   logic [8:0] high_sum;
   logic high_pending;
   logic low_pending;
   logic any_pending;

   // Return address and working context go to the fast return store
   isrc_shadow_mem #(
      .DEPTH(isrc_pkg::SH_DEPTH),
      .WIDTH(8)
   ) u_shadow (
      .mclk(mclk),
      .rst_n(rst_n),
      .store(irq_entry),
      .store_data({return_pc[15:8], return_pc[7:0], bank_select_register,
                   status_register, working_register}),
      .rd_addr(shadow_addr),
      .rd_data(shadow_rdata)
   );

   // Map address to shadow slot
   always_comb
   begin
      if (reg_addr == isrc_pkg::ADDR_SHADOW_STATUS)
      begin
         shadow_addr = isrc_pkg::SH_STATUS;
      end
      else if (reg_addr == isrc_pkg::ADDR_SHADOW_BANK)
      begin
         shadow_addr = isrc_pkg::SH_BANK;
      end
      else if (reg_addr == isrc_pkg::ADDR_SHADOW_PC_LO)
      begin
         shadow_addr = isrc_pkg::SH_PC_LO;
      end
      else if (reg_addr == isrc_pkg::ADDR_SHADOW_PC_HI)
      begin
         shadow_addr = isrc_pkg::SH_PC_HI;
      end
      else
      begin
         shadow_addr = isrc_pkg::SH_W;
      end
   end

   // Per-pin fields gathered from the control registers
   assign ext_flag = {st_reg.irq_control_third[isrc_pkg::C3_EXT2_FLAG],
                      st_reg.irq_control_third[isrc_pkg::C3_EXT1_FLAG],
                      st_reg.irq_control_main[isrc_pkg::CM_EXT0_FLAG]};
   assign ext_en = {st_reg.irq_control_third[isrc_pkg::C3_EXT2_EN],
                    st_reg.irq_control_third[isrc_pkg::C3_EXT1_EN],
                    st_reg.irq_control_main[isrc_pkg::CM_EXT0_EN]};
   assign ext_edge = {st_reg.irq_control_second[isrc_pkg::C2_EDGE2],
                      st_reg.irq_control_second[isrc_pkg::C2_EDGE1],
                      st_reg.irq_control_second[isrc_pkg::C2_EDGE0]};
   // Pin zero has no priority bit and is always high
   assign ext_prio = {st_reg.irq_control_third[isrc_pkg::C3_EXT2_PRIO],
                      st_reg.irq_control_third[isrc_pkg::C3_EXT1_PRIO],
                      1'b1};

   // Edge detection on synchronised pins, direction per select bit
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_ext
         assign ext_event[gi] = ext_edge[gi] ?
            (st_reg.ext_sync[gi] & ~st_reg.ext_prev[gi]) :
            (~st_reg.ext_sync[gi] & st_reg.ext_prev[gi]);
      end
      for (gi = 0; gi < 4; gi++)
      begin : g_chg
         assign chg_event[gi] = st_reg.pin_change_enable_mask[gi] &
            (st_reg.chg_sync[gi] ^ st_reg.chg_prev[gi]);
      end
   endgenerate

   // Timer increments; carry marks the rollover for the active mode
   assign low_sum = {1'b0, st_reg.timer_count_low} + 9'h001;
   assign high_sum = {1'b0, st_reg.timer_count_high} + 9'h001;
   assign timer_wrap = st_reg.timer_cfg[isrc_pkg::TC_RUN] & low_sum[8] &
      (~st_reg.timer_cfg[isrc_pkg::TC_WIDE] | high_sum[8]);

   // Request levels; single-level mode routes all to the high line
   always_comb
   begin
      logic [2:0] ext_req;
      logic tmr_req;
      logic chg_req;
      ext_req = ext_flag & ext_en;
      tmr_req = st_reg.irq_control_main[isrc_pkg::CM_TIMER_FLAG] &
                st_reg.irq_control_main[isrc_pkg::CM_TIMER_EN];
      chg_req = st_reg.irq_control_main[isrc_pkg::CM_CHANGE_FLAG] &
                st_reg.irq_control_main[isrc_pkg::CM_CHANGE_EN];
      any_pending = |ext_req | tmr_req | chg_req;
      if (st_reg.reset_cause_control[isrc_pkg::RC_PRIO_EN])
      begin
         // A priority bit of one means high, zero means low
         high_pending = |(ext_req & ext_prio) |
            (tmr_req & st_reg.irq_control_second[isrc_pkg::C2_TIMER_PRIO]) |
            (chg_req & st_reg.irq_control_second[isrc_pkg::C2_CHANGE_PRIO]);
         low_pending = |(ext_req & ~ext_prio) |
            (tmr_req & ~st_reg.irq_control_second[isrc_pkg::C2_TIMER_PRIO]) |
            (chg_req & ~st_reg.irq_control_second[isrc_pkg::C2_CHANGE_PRIO]);
      end
      else
      begin
         high_pending = any_pending;
         low_pending = 1'b0;
      end
   end

   // Next state: register writes, then hardware sets which win over clears
   always_comb
   begin
      logic [7:0] rc;
      rc = st_reg.reset_cause_control;
      st_next = st_reg;
      st_next.ext_meta = ext_irq_pin;
      st_next.ext_sync = st_reg.ext_meta;
      st_next.ext_prev = st_reg.ext_sync;
      st_next.chg_meta = port_change_pin;
      st_next.chg_sync = st_reg.chg_meta;
      st_next.chg_prev = st_reg.chg_sync;
      // Software writes
      if (reg_wr)
      begin
         if (reg_addr == isrc_pkg::ADDR_RESET_CAUSE)
         begin
            st_next.reset_cause_control = (rc & ~isrc_pkg::RC_WRITE_MASK) |
               (reg_wdata & isrc_pkg::RC_WRITE_MASK);
         end
         else if (reg_addr == isrc_pkg::ADDR_CTRL_MAIN)
         begin
            st_next.irq_control_main = reg_wdata;
         end
         else if (reg_addr == isrc_pkg::ADDR_CTRL_SECOND)
         begin
            st_next.irq_control_second = reg_wdata & isrc_pkg::C2_WRITE_MASK;
         end
         else if (reg_addr == isrc_pkg::ADDR_CTRL_THIRD)
         begin
            st_next.irq_control_third = reg_wdata & isrc_pkg::C3_WRITE_MASK;
         end
         else if (reg_addr == isrc_pkg::ADDR_PIN_CHANGE)
         begin
            st_next.pin_change_enable_mask = reg_wdata[3:0];
         end
         else if (reg_addr == isrc_pkg::ADDR_TIMER_LOW)
         begin
            st_next.timer_count_low = reg_wdata;
         end
         else if (reg_addr == isrc_pkg::ADDR_TIMER_HIGH)
         begin
            st_next.timer_count_high = reg_wdata;
         end
         else if (reg_addr == isrc_pkg::ADDR_TIMER_CFG)
         begin
            st_next.timer_cfg = reg_wdata & isrc_pkg::TC_WRITE_MASK;
         end
      end
      // Timer counting, suspended by a write to a count byte
      if (st_reg.timer_cfg[isrc_pkg::TC_RUN] && !(reg_wr &&
          (reg_addr == isrc_pkg::ADDR_TIMER_LOW || reg_addr == isrc_pkg::ADDR_TIMER_HIGH)))
      begin
         st_next.timer_count_low = low_sum[7:0];
         if (st_reg.timer_cfg[isrc_pkg::TC_WIDE] && low_sum[8])
            st_next.timer_count_high = high_sum[7:0];
      end
      // Hardware flag sets, latched regardless of interrupt enable; change flag needs its pin mask bit
      if (ext_event[0])
         st_next.irq_control_main[isrc_pkg::CM_EXT0_FLAG] = 1'b1;
      if (ext_event[1])
         st_next.irq_control_third[isrc_pkg::C3_EXT1_FLAG] = 1'b1;
      if (ext_event[2])
         st_next.irq_control_third[isrc_pkg::C3_EXT2_FLAG] = 1'b1;
      if (timer_wrap)
         st_next.irq_control_main[isrc_pkg::CM_TIMER_FLAG] = 1'b1;
      if (|chg_event)
         st_next.irq_control_main[isrc_pkg::CM_CHANGE_FLAG] = 1'b1;
      // Reset cause status cleared by core events
      if (cause_reset_instr)
         st_next.reset_cause_control[isrc_pkg::RC_RESET_INSTR] = 1'b0;
      if (cause_watchdog)
         st_next.reset_cause_control[isrc_pkg::RC_WDT_TIMEOUT] = 1'b0;
      if (cause_sleep)
         st_next.reset_cause_control[isrc_pkg::RC_POWER_DOWN] = 1'b0;
      // Wake arming: enables captured while running
      if (!low_power_mode)
         st_next.wake_armed = ext_en;
      st_next.wake_up = low_power_mode & |(st_reg.wake_armed & ext_flag);
      st_next.branch_vector = st_next.wake_up &
         st_reg.irq_control_main[isrc_pkg::CM_GLOBAL_EN];
      st_next.irq_high = high_pending;
      st_next.irq_low = low_pending;
      // Read path: data valid the cycle after the strobe
      st_next.rd_shadow = 1'b0;
      st_next.rd_data = isrc_pkg::BYTE_ZERO;
      if (reg_rd)
      begin
         if (reg_addr == isrc_pkg::ADDR_RESET_CAUSE)
         begin
            st_next.rd_data = st_reg.reset_cause_control &
               ~(8'h01 << isrc_pkg::RC_SBOR_EN - 1);
         end
         else if (reg_addr == isrc_pkg::ADDR_CTRL_MAIN)
         begin
            st_next.rd_data = st_reg.irq_control_main;
         end
         else if (reg_addr == isrc_pkg::ADDR_CTRL_SECOND)
         begin
            st_next.rd_data = st_reg.irq_control_second;
         end
         else if (reg_addr == isrc_pkg::ADDR_CTRL_THIRD)
         begin
            st_next.rd_data = st_reg.irq_control_third;
         end
         else if (reg_addr == isrc_pkg::ADDR_PIN_CHANGE)
         begin
            st_next.rd_data = {isrc_pkg::NIB_ZERO, st_reg.pin_change_enable_mask};
         end
         else if (reg_addr == isrc_pkg::ADDR_TIMER_LOW)
         begin
            st_next.rd_data = st_reg.timer_count_low;
         end
         else if (reg_addr == isrc_pkg::ADDR_TIMER_HIGH)
         begin
            st_next.rd_data = st_reg.timer_count_high;
         end
         else if (reg_addr == isrc_pkg::ADDR_TIMER_CFG)
         begin
            st_next.rd_data = st_reg.timer_cfg;
         end
         else if (reg_addr >= isrc_pkg::ADDR_SHADOW_W &&
                  reg_addr <= isrc_pkg::ADDR_SHADOW_PC_HI)
         begin
            st_next.rd_shadow = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg <= '0;
         st_reg.reset_cause_control <= isrc_pkg::RC_RESET_VALUE;
         st_reg.irq_control_second <= isrc_pkg::C2_RESET_VALUE;
         st_reg.irq_control_third <= isrc_pkg::C3_RESET_VALUE;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Read data: shadow slots come from the store's own output register
   assign reg_rdata = st_reg.rd_shadow ? shadow_rdata : st_reg.rd_data;

   assign irq_high = st_reg.irq_high;
   assign irq_low = st_reg.irq_low;
   assign wake_up = st_reg.wake_up;
   assign branch_vector = st_reg.branch_vector;
   assign priority_levels_enable = st_reg.reset_cause_control[isrc_pkg::RC_PRIO_EN];
endmodule // isrc_top

// file: isrc_pkg.sv
// Package for the interrupt source and reset cause block.
// Assumes a single 200 MHz core clock domain and an 8-bit register port.
package isrc_pkg;
   // Register port addresses
   localparam logic [3:0] ADDR_RESET_CAUSE = 4'h0;
   localparam logic [3:0] ADDR_CTRL_MAIN = 4'h1;
   localparam logic [3:0] ADDR_CTRL_SECOND = 4'h2;
   localparam logic [3:0] ADDR_CTRL_THIRD = 4'h3;
   localparam logic [3:0] ADDR_PIN_CHANGE = 4'h4;
   localparam logic [3:0] ADDR_TIMER_LOW = 4'h5;
   localparam logic [3:0] ADDR_TIMER_HIGH = 4'h6;
   localparam logic [3:0] ADDR_TIMER_CFG = 4'h7;
   localparam logic [3:0] ADDR_SHADOW_W = 4'h8;
   localparam logic [3:0] ADDR_SHADOW_STATUS = 4'h9;
   localparam logic [3:0] ADDR_SHADOW_BANK = 4'hA;
   localparam logic [3:0] ADDR_SHADOW_PC_LO = 4'hB;
   localparam logic [3:0] ADDR_SHADOW_PC_HI = 4'hC;
   // Reset cause field positions
   localparam int RC_PRIO_EN = 7;
   localparam int RC_SBOR_EN = 6;
   localparam int RC_RESET_INSTR = 4;
   localparam int RC_WDT_TIMEOUT = 3;
   localparam int RC_POWER_DOWN = 2;
   localparam int RC_POWER_ON = 1;
   localparam int RC_BROWNOUT = 0;
   // Writable bits and power-on value of the reset cause register
   localparam logic [7:0] RC_WRITE_MASK = 8'hD3;
   localparam logic [7:0] RC_RESET_VALUE = 8'h5C;
   // Main control field positions
   localparam int CM_GLOBAL_EN = 7;
   localparam int CM_PERIPH_EN = 6;
   localparam int CM_TIMER_EN = 5;
   localparam int CM_EXT0_EN = 4;
   localparam int CM_CHANGE_EN = 3;
   localparam int CM_TIMER_FLAG = 2;
   localparam int CM_EXT0_FLAG = 1;
   localparam int CM_CHANGE_FLAG = 0;
   // Second control field positions
   localparam int C2_EDGE0 = 6;
   localparam int C2_EDGE1 = 5;
   localparam int C2_EDGE2 = 4;
   localparam int C2_TIMER_PRIO = 2;
   localparam int C2_CHANGE_PRIO = 0;
   localparam logic [7:0] C2_RESET_VALUE = 8'hF5;
   localparam logic [7:0] C2_WRITE_MASK = 8'hF5;
   // Third control field positions
   localparam int C3_EXT2_PRIO = 7;
   localparam int C3_EXT1_PRIO = 6;
   localparam int C3_EXT2_EN = 4;
   localparam int C3_EXT1_EN = 3;
   localparam int C3_EXT2_FLAG = 1;
   localparam int C3_EXT1_FLAG = 0;
   localparam logic [7:0] C3_RESET_VALUE = 8'hC0;
   localparam logic [7:0] C3_WRITE_MASK = 8'hDB;
   // Timer configuration: bit 0 selects 16-bit mode, bit 1 runs the timer
   localparam int TC_WIDE = 0;
   localparam int TC_RUN = 1;
   localparam logic [7:0] TC_WRITE_MASK = 8'h03;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ALL = 8'hFF;
   localparam logic [3:0] NIB_ZERO = 4'h0;
   // Shadow store slots
   localparam logic [2:0] SH_W = 3'h0;
   localparam logic [2:0] SH_STATUS = 3'h1;
   localparam logic [2:0] SH_BANK = 3'h2;
   localparam logic [2:0] SH_PC_LO = 3'h3;
   localparam logic [2:0] SH_PC_HI = 3'h4;
   localparam int SH_DEPTH = 5;
endpackage

// file: isrc_shadow_mem.sv
`timescale 1ns/1ps
// Small register file holding the context saved at interrupt entry.
// Assumes one writer that stores all slots in one cycle; registered read.
module isrc_shadow_mem #(
   parameter int DEPTH = 5,
   parameter int WIDTH = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic store,
   input wire logic [DEPTH*WIDTH-1:0] store_data,
   input wire logic [2:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [DEPTH-1:0][WIDTH-1:0] mem_reg;

   // All slots capture together at entry
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_reg <= '0;
         rd_data <= '0;
      end
      else
      begin
         if (store)
         begin
            mem_reg <= store_data;
         end
         if (32'(rd_addr) < DEPTH)
         begin
            rd_data <= mem_reg[rd_addr];
         end
         else
         begin
            rd_data <= '0;
         end
      end
   end
endmodule // isrc_shadow_mem

// file: isrc_top_checker.sv
`timescale 1ns/1ps
// Concurrent checks on the ports of the interrupt source block.
// Assumes one clock domain and the register map of the block package.
module isrc_top_checker (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [2:0] ext_irq_pin,
   input wire logic [3:0] port_change_pin,
   input wire logic low_power_mode,
   input wire logic irq_entry,
   input wire logic [15:0] return_pc,
   input wire logic [7:0] working_register,
   input wire logic [7:0] status_register,
   input wire logic [7:0] bank_select_register,
   input wire logic cause_reset_instr,
   input wire logic cause_watchdog,
   input wire logic cause_sleep,
   input wire logic irq_high,
   input wire logic irq_low,
   input wire logic wake_up,
   input wire logic branch_vector,
   input wire logic priority_levels_enable
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // Steps of a reset cause access
   sequence rc_write;
      reg_wr && reg_addr == isrc_pkg::ADDR_RESET_CAUSE;
   endsequence
   sequence rc_read;
      reg_rd && reg_addr == isrc_pkg::ADDR_RESET_CAUSE;
   endsequence

   // Reset cause register behaviour
   rc_writeback_a: assert property (rc_write ##1 rc_read |=>
      (reg_rdata & 8'hC3) == ($past(reg_wdata, 2) & 8'hC3)) else $error("reset cause writeback");
   prio_mirror_a: assert property (rc_read |=> reg_rdata[7] == priority_levels_enable)
      else $error("priority port differs from bit 7");
   rc_bit5_a: assert property (rc_read |=> !reg_rdata[5])
      else $error("unused bit reads one");
   to_clear_a: assert property (cause_watchdog ##1 rc_read |=> !reg_rdata[3])
      else $error("time-out flag not cleared");
   pd_clear_a: assert property (cause_sleep ##1 rc_read |=> !reg_rdata[2])
      else $error("power-down flag not cleared");
   // Read data port
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   unmapped_zero_a: assert property ($past(reg_rd) && $past(reg_addr) > isrc_pkg::ADDR_SHADOW_PC_HI
      |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
   // Low level exists only with priorities on
   low_needs_prio_a: assert property (irq_low |-> priority_levels_enable ||
      $past(priority_levels_enable)) else $error("low request in single level mode");
endmodule // isrc_top_checker

bind isrc_top isrc_top_checker chk_u (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .ext_irq_pin, .port_change_pin, .low_power_mode, .irq_entry, .return_pc,
   .working_register, .status_register, .bank_select_register, .cause_reset_instr,
   .cause_watchdog, .cause_sleep, .irq_high, .irq_low, .wake_up, .branch_vector,
   .priority_levels_enable);

// file: isrc_pin_model.sv
`timescale 1ns/1ps
// Outside world on the interrupt pins and the upper port pins.
// Assumes the bench sets the wanted levels; pins move off the clock edge.
module isrc_pin_model (
   input wire logic mclk,
   input wire logic [2:0] pin_level,
   input wire logic [3:0] change_level,
   output logic [2:0] ext_irq_pin,
   output logic [3:0] port_change_pin
);
   logic [2:0] pin_q = 3'h0;
   logic [3:0] chg_q = 4'h0;
   // Pins are asynchronous, so they change a little after the edge
   always @(posedge mclk)
   begin
      #2;
      pin_q <= pin_level;
      chg_q <= change_level;
   end
   assign ext_irq_pin = pin_q;
   assign port_change_pin = chg_q;
endmodule // isrc_pin_model

// file: isrc_top_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the interrupt source block.
// Assumes the pin model on the far side and the plain register port.
module isrc_top_tb;
   localparam logic [3:0] RC = isrc_pkg::ADDR_RESET_CAUSE;
   localparam logic [3:0] MAIN = isrc_pkg::ADDR_CTRL_MAIN;
   localparam logic [3:0] C2 = isrc_pkg::ADDR_CTRL_SECOND;
   localparam logic [3:0] C3 = isrc_pkg::ADDR_CTRL_THIRD;
   localparam logic [3:0] TCFG = isrc_pkg::ADDR_TIMER_CFG;
   logic mclk, rst_n, reg_wr, reg_rd, low_power_mode, irq_entry;
   logic cause_reset_instr, cause_watchdog, cause_sleep;
   logic irq_high, irq_low, wake_up, branch_vector, priority_levels_enable;
   logic [2:0] cause_vec, pin_level, ext_irq_pin;
   logic [3:0] reg_addr, change_level, port_change_pin;
   logic [7:0] reg_wdata, reg_rdata, working_register, status_register, bank_select_register;
   logic [7:0] exp;
   logic [15:0] return_pc;
   int mismatches, tests_run;
   assign {cause_reset_instr, cause_watchdog, cause_sleep} = cause_vec;
   isrc_top dut_u (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .ext_irq_pin, .port_change_pin, .low_power_mode, .irq_entry, .return_pc,
      .working_register, .status_register, .bank_select_register, .cause_reset_instr,
      .cause_watchdog, .cause_sleep, .irq_high, .irq_low, .wake_up, .branch_vector,
      .priority_levels_enable);
   isrc_pin_model pins_u (.mclk, .pin_level, .change_level, .ext_irq_pin, .port_change_pin);
   // Clock at 200 MHz
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Comparison, access and verdict helpers
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
      tests_run++;
      if (seen !== want)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic lvl(input string what, input logic seen, input logic want);
      check(what, {7'h00, seen}, {7'h00, want});
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] want);
      reg_addr <= a;
      reg_rd <= 1'b1;
      reg_wr <= 1'b0;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      check($sformatf("register %h", a), reg_rdata, want);
   endtask
   task automatic cyc(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask
   task automatic give_verdict();
      if (mismatches == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      repeat (5000) @(posedge mclk);
      mismatches++;
      give_verdict();
   end
   // Test sequence
   initial
   begin
      mismatches = 0;
      tests_run = 0;
      rst_n = 1'b0;
      {reg_wr, reg_rd, low_power_mode, irq_entry} = 4'h0;
      {reg_addr, reg_wdata, cause_vec, pin_level, change_level} = 22'h00_0000;
      return_pc = 16'h1234;
      {working_register, status_register, bank_select_register} = 24'hA5_5A3C;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rc(RC, 8'h5C);
      rc(C2, isrc_pkg::C2_RESET_VALUE);
      rc(C3, isrc_pkg::C3_RESET_VALUE);
      rc(4'hE, 8'h00);
      wr(RC, 8'hB3);
      rc(RC, 8'h9F);
      exp = 8'h9F;
      for (int k = 2; k >= 0; k--)
      begin
         cause_vec <= 3'h1 << k;
         @(posedge mclk);
         cause_vec <= 3'h0;
         exp = exp & ~(8'h04 << k);
         rc(RC, exp);
      end
      wr(RC, 8'hFF);
      rc(RC, 8'hD3);
      lvl("priority_levels_enable", priority_levels_enable, 1'b1);
      pin_level[0] <= 1'b1;
      cyc(6);
      rc(MAIN, 8'h02);
      lvl("irq_high", irq_high, 1'b0);
      wr(MAIN, 8'h92);
      cyc(3);
      lvl("irq_high", irq_high, 1'b1);
      wr(MAIN, 8'h90);
      cyc(3);
      lvl("irq_high", irq_high, 1'b0);
      wr(C2, 8'hB5);
      pin_level[0] <= 1'b0;
      cyc(6);
      rc(MAIN, 8'h92);
      wr(MAIN, 8'h90);
      pin_level[0] <= 1'b1;
      cyc(6);
      rc(MAIN, 8'h90);
      // Pins one and two with each priority setting
      for (int i = 1; i <= 2; i++)
         for (int p = 0; p <= 1; p++)
         begin
            wr(C3, (8'h04 << i) | ((p == 1 ? 8'h20 : 8'h00) << i));
            pin_level[i] <= 1'b1;
            cyc(6);
            lvl("irq_low", irq_low, p == 0);
            lvl("irq_high", irq_high, p == 1);
            pin_level[i] <= 1'b0;
            cyc(1);
         end
      wr(C3, 8'h00);
      // Port change, masked then unmasked
      wr(isrc_pkg::ADDR_PIN_CHANGE, 8'h00);
      wr(MAIN, 8'h88);
      change_level <= 4'h1;
      cyc(6);
      rc(MAIN, 8'h88);
      wr(isrc_pkg::ADDR_PIN_CHANGE, 8'hFF);
      change_level <= 4'h0;
      cyc(6);
      rc(MAIN, 8'h89);
      lvl("irq_high", irq_high, 1'b1);
      wr(MAIN, 8'h80);
      // Timer rollover, gating and priority
      wr(isrc_pkg::ADDR_TIMER_LOW, 8'hFD);
      wr(TCFG, 8'h02);
      cyc(8);
      rc(MAIN, 8'h84);
      wr(C2, 8'hB1);
      wr(MAIN, 8'hA4);
      cyc(3);
      lvl("irq_low", irq_low, 1'b1);
      // Single-level mode moves the same request to the high line
      wr(RC, 8'h00);
      cyc(3);
      lvl("irq_high", irq_high, 1'b1);
      lvl("irq_low", irq_low, 1'b0);
      wr(MAIN, 8'h80);
      for (int h = 0; h <= 1; h++)
      begin
         wr(TCFG, 8'h00);
         wr(isrc_pkg::ADDR_TIMER_HIGH, h == 1 ? 8'hFF : 8'h00);
         wr(isrc_pkg::ADDR_TIMER_LOW, 8'hFD);
         wr(TCFG, 8'h03);
         cyc(8);
         rc(MAIN, h == 1 ? 8'h84 : 8'h80);
      end
      wr(TCFG, 8'h00);
      // Wake from low power, then context capture
      wr(MAIN, 8'h90);
      cyc(1);
      low_power_mode <= 1'b1;
      cyc(2);
      pin_level[0] <= 1'b0;
      cyc(6);
      lvl("wake_up", wake_up, 1'b1);
      lvl("branch_vector", branch_vector, 1'b1);
      low_power_mode <= 1'b0;
      irq_entry <= 1'b1;
      @(posedge mclk);
      irq_entry <= 1'b0;
      rc(isrc_pkg::ADDR_SHADOW_W, 8'hA5);
      rc(isrc_pkg::ADDR_SHADOW_STATUS, 8'h5A);
      rc(isrc_pkg::ADDR_SHADOW_BANK, 8'h3C);
      rc(isrc_pkg::ADDR_SHADOW_PC_LO, 8'h34);
      rc(isrc_pkg::ADDR_SHADOW_PC_HI, 8'h12);
      give_verdict();
   end
endmodule // isrc_top_tb
